// ==== core/rcr_defines.svh ====
// Register map, field positions, reset values and command codes of the radio register bank.
// Assumes inclusion by bare name from any design file that decodes the serial link.
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

// ==========================================================================
// First-bank register offsets
`define RCR_ADDR_CONFIG        5'h00
`define RCR_ADDR_AUTO_ACK      5'h01
`define RCR_ADDR_RX_PIPES      5'h02
`define RCR_ADDR_STATUS        5'h07

// ==========================================================================
// Reset values and writable masks
`define RCR_CFG_RST            8'h08
`define RCR_AA_RST             8'h3f
`define RCR_RXEN_RST           8'h03
`define RCR_CFG_MASK           8'h7f
`define RCR_PIPE_MASK          8'h3f

// ==========================================================================
// Field positions
`define RCR_BIT_MASK_HI        6
`define RCR_BIT_MASK_LO        4
`define RCR_BIT_CRC_EN         3
`define RCR_BIT_CRC_LEN        2
`define RCR_BIT_POWER_UP_CONTROL         1
`define RCR_BIT_PRIMARY_ROLE_SELECT        0
`define RCR_BIT_FLAG_RX        2
`define RCR_BIT_CLR_HI         6
`define RCR_BIT_CLR_LO         4

// ==========================================================================
// Commands, bank handling and status constants
`define RCR_CMD_READ_TOP       3'h0
`define RCR_CMD_WRITE_TOP      3'h1
`define RCR_CMD_ACTIVATE       8'h50
`define RCR_ACT_BANK_DATA      8'h53
`define RCR_BANK1_REV_LAST     5'h08
`define RCR_BANK1_BYTES        3'h4
`define RCR_STATUS_PIPE_EMPTY  3'h7
`define RCR_LAST_BIT           3'h7
`define RCR_LAST_IDX           3'h7

`endif

// ==== core/rcr_pkg.sv ====
// Types shared by the radio register bank: link phases, request and state carriers.
// Assumes nothing beyond a SystemVerilog compiler; holds no numbers of the map.
package rcr_pkg;

   // ==========================================================================
   // Serial frame phase, one-hot
   typedef enum logic [1:0] {
      RCR_PH_COMMAND = 2'b01,
      RCR_PH_DATA    = 2'b10
   } rcr_phase_type;

   // Kind of request handed from the link to the system side
   typedef enum logic [1:0] {
      RCR_REQ_WRITE    = 2'b01,
      RCR_REQ_ACTIVATE = 2'b10
   } rcr_req_kind_type;

   // ==========================================================================
   // Carriers
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] cfg;
      logic [7:0] auto_ack;
      logic [7:0] rx_pipes;
   } rcr_view_type;

   typedef struct packed {
      rcr_req_kind_type kind;
      logic             bank;
      logic [4:0]       addr;
      logic [7:0]       data;
   } rcr_req_type;

   typedef struct packed {
      logic        toggle;
      rcr_req_type req;
   } rcr_deliver_type;

   typedef struct packed {
      rcr_phase_type phase;
      logic [2:0]    bit_cnt;
      logic [2:0]    byte_idx;
      logic [7:0]    cmd;
      logic [6:0]    shift_in;
      logic          bank;
   } rcr_link_state_type;

   typedef struct packed {
      logic       link_rst_n;
      logic       tog_prev;
      logic [7:0] cfg;
      logic [7:0] aa;
      logic [7:0] rxen;
      logic [2:0] flags;
      logic       bank;
      logic       crc_eff;
      logic       irq_n;
   } rcr_sys_state_type;

endpackage : rcr_pkg

// ==== core/rcr_sync.sv ====
// Two-flop level synchroniser of parameterised width.
// Assumes each bit is a level that stays put for several destination clocks.
`timescale 1ns/1ps
module rcr_sync #(
   parameter int WIDTH = 1
) (
   // Destination clock and synchronous reset
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // Level in and out
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } rcr_sync_state_type;

   rcr_sync_state_type s_r;
   rcr_sync_state_type s_nxt;

   // ==========================================================================
   // Width check
   if (WIDTH < 1) begin : g_bad_width
      $error("rcr_sync needs a width of at least one");
   end

   // First stage feeds only the second
   always_comb begin
      s_nxt.meta   = d_i;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.stable;
endmodule : rcr_sync

// ==== core/rcr_link.sv ====
// Serial link slave of the register bank, clocked by the link's own serial clock.
// Assumes mode 0 framing: sampled on rising edges, shifted out on falling edges.
`timescale 1ns/1ps
`include "rcr_defines.svh"
module rcr_link (
   // Link clock, frame and reset from the system side
   input  wire logic                    sck_i,
   input  wire logic                    csn_i,
   input  wire logic                    mosi_i,
   input  wire logic                    link_rst_n_i,
   // Synchronised register view
   input  wire rcr_pkg::rcr_view_type   view_i,
   // Requests toward the system clock
   output rcr_pkg::rcr_deliver_type     deliver_o,
   // Serial output pin
   output logic                         miso_o,
   output logic                         miso_oe_n_o
);
   rcr_pkg::rcr_link_state_type s_r, s_nxt;
   rcr_pkg::rcr_deliver_type    d_r, d_nxt;
   logic [7:0]                  in_byte;
   // Output shifter lives apart: it is the only falling-edge register
   logic [7:0]                  out_r, out_nxt;
   logic                        frame_rst;

   // Bytes of low second-bank registers travel most significant first
   function automatic logic [2:0] lane_of(input logic bank, input logic [4:0] addr,
                                          input logic [2:0] idx);
      lane_of = (bank && addr <= `RCR_BANK1_REV_LAST) ? 3'(`RCR_BANK1_BYTES - 3'h1 - idx)
                                                     : idx;
   endfunction : lane_of

   // Read data for one byte of a read command; second bank reads as zero
   function automatic logic [7:0] read_byte(input rcr_pkg::rcr_view_type v,
                                            input logic bank, input logic [7:0] cmd,
                                            input logic [2:0] idx);
      read_byte = 8'h00;
      if (cmd[7:5] == `RCR_CMD_READ_TOP && !bank && lane_of(bank, cmd[4:0], idx) == 3'h0) begin
         case (cmd[4:0])
            `RCR_ADDR_CONFIG:   read_byte = v.cfg;
            `RCR_ADDR_AUTO_ACK: read_byte = v.auto_ack;
            `RCR_ADDR_RX_PIPES: read_byte = v.rx_pipes;
            `RCR_ADDR_STATUS:   read_byte = v.status;
            default:            read_byte = 8'h00;
         endcase
      end
   endfunction : read_byte

   // Frame state restarts whenever the chip select is released
   assign frame_rst = csn_i | ~link_rst_n_i;

   // ==========================================================================
   // Rising edge: sample, decode, hand over writes
   always_comb begin
      s_nxt          = s_r;
      d_nxt          = d_r;
      in_byte        = {s_r.shift_in, mosi_i};
      s_nxt.shift_in = in_byte[6:0];
      s_nxt.bit_cnt  = s_r.bit_cnt + 3'h1;
      if (s_r.bit_cnt == `RCR_LAST_BIT) begin
         case (s_r.phase)
            rcr_pkg::RCR_PH_COMMAND: begin
               s_nxt.cmd      = in_byte;
               s_nxt.bank     = view_i.status[7];
               s_nxt.byte_idx = 3'h0;
               s_nxt.phase    = rcr_pkg::RCR_PH_DATA;
            end
            rcr_pkg::RCR_PH_DATA: begin
               if (s_r.byte_idx != `RCR_LAST_IDX) begin
                  s_nxt.byte_idx = s_r.byte_idx + 3'h1;
               end
               // Only the first data byte reaches a one-byte register
               if (s_r.byte_idx == 3'h0 && (s_r.cmd[7:5] == `RCR_CMD_WRITE_TOP ||
                                             s_r.cmd == `RCR_CMD_ACTIVATE)) begin
                  d_nxt.toggle   = ~d_r.toggle;
                  d_nxt.req.kind = (s_r.cmd == `RCR_CMD_ACTIVATE) ? rcr_pkg::RCR_REQ_ACTIVATE
                                                                  : rcr_pkg::RCR_REQ_WRITE;
                  d_nxt.req.bank = s_r.bank;
                  d_nxt.req.addr = s_r.cmd[4:0];
                  d_nxt.req.data = in_byte;
               end
            end
            default: s_nxt.phase = rcr_pkg::RCR_PH_COMMAND;
         endcase
      end
      // Falling-edge part: load read data at a byte start, else shift
      if (s_r.phase == rcr_pkg::RCR_PH_DATA && s_r.bit_cnt == 3'h0) begin
         out_nxt = read_byte(view_i, s_r.bank, s_r.cmd, s_r.byte_idx);
      end else begin
         out_nxt = {out_r[6:0], 1'b0};
      end
   end

   // Receive fields on rising edges; output shifter holds on them
   always_ff @(posedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         s_r.phase    <= rcr_pkg::RCR_PH_COMMAND;
         s_r.bit_cnt  <= 3'h0;
         s_r.byte_idx <= 3'h0;
         s_r.cmd      <= 8'hff;
         s_r.shift_in <= 7'h00;
         s_r.bank     <= 1'b0;
      end else begin
         s_r.phase    <= s_nxt.phase;
         s_r.bit_cnt  <= s_nxt.bit_cnt;
         s_r.byte_idx <= s_nxt.byte_idx;
         s_r.cmd      <= s_nxt.cmd;
         s_r.shift_in <= s_nxt.shift_in;
         s_r.bank     <= s_nxt.bank;
      end
   end

   // Output shifter moves on falling edges so data settle before sampling
   always_ff @(negedge sck_i or posedge frame_rst) begin
      if (frame_rst) begin
         out_r <= 8'h00;
      end else begin
         out_r <= out_nxt;
      end
   end

   // Request hold survives frame ends; only the system reset clears it
   always_ff @(posedge sck_i or negedge link_rst_n_i) begin
      if (!link_rst_n_i) begin
         d_r <= '0;
      end else begin
         d_r <= d_nxt;
      end
   end

   // Status leaves during the command byte, register data after it
   assign miso_o      = (s_r.phase == rcr_pkg::RCR_PH_COMMAND) ?
                        view_i.status[3'h7 - s_r.bit_cnt] : out_r[7];
   assign miso_oe_n_o = csn_i;
   assign deliver_o   = d_r;
endmodule : rcr_link

// ==== core/rcr_top.sv ====
// Radio register bank: first-bank configuration, pipe enables, status flags, bank toggle.
// Assumes a serial master on the four-wire link and event pulses on the system clock.
//
// Overview of operation
// - Multi-byte link data go low byte first, each byte high bit first.
// - Second-bank registers 0 to 8 send their high byte first; 9 to 14 do not.
// - Activate command followed by data 0x53 toggles the selected register bank.
// - Status bit 7 shows the selected bank: 0 first, 1 second.
// - Config bits 6,5,4 mask receive, transmit and retry events from the interrupt pin.
// - Checksum enable bit 3 resets high and reads high when any auto-ack bit is set.
// - Checksum length bit 2: 0 one byte, 1 two bytes; resets to 0.
// - Bit 1 powers up, bit 0 selects primary receiver; both reset to 0.
// - Auto-ack register: pipe enables in bits 5..0, reset 1; bits 7:6 stay 0.
// - Status shifts out on the serial output while the command byte shifts in.
// - Receive-ready flag sets on new receive data and clears on a written 1.
`timescale 1ns/1ps
`include "rcr_defines.svh"
module rcr_top (
   // System clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       nrst_i,
   // Serial link pins
   input  wire logic       sck_i,
   input  wire logic       csn_i,
   input  wire logic       mosi_i,
   output logic            miso_o,
   output logic            miso_oe_n_o,
   // Packet engine events, one-cycle pulses
   input  wire logic       rx_ready_evt_i,
   input  wire logic       tx_done_evt_i,
   input  wire logic       retry_limit_evt_i,
   // Interrupt pin, active low
   output logic            irq_n_o,
   // Configuration toward the radio
   output logic            power_up_o,
   output logic            primary_role_o,
   output logic            crc_enable_o,
   output logic            checksum_length_o,
   output logic [5:0]      auto_ack_o,
   output logic [5:0]      rx_pipe_en_o,
   output logic            bank_o
);
   // ==========================================================================
   // State and reset image
   localparam rcr_pkg::rcr_sys_state_type RST_STATE = '{
      link_rst_n: 1'b0,
      tog_prev:   1'b0,
      cfg:        `RCR_CFG_RST,
      aa:         `RCR_AA_RST,
      rxen:       `RCR_RXEN_RST,
      flags:      3'h0,
      bank:       1'b0,
      crc_eff:    1'b1,
      irq_n:      1'b1
   };

   rcr_pkg::rcr_sys_state_type r;
   rcr_pkg::rcr_sys_state_type nx;
   rcr_pkg::rcr_view_type      view;
   rcr_pkg::rcr_view_type      view_link;
   rcr_pkg::rcr_view_type      view_mix;
   rcr_pkg::rcr_deliver_type   deliver;
   logic                       tog_sync;
   logic                       take;
   logic                       wr_bank0;
   logic [2:0]                 clr;
   logic [2:0]                 evt;

   // ==========================================================================
   // Link side: serial slave on its own clock
   rcr_link u_link (
      .sck_i        (sck_i),
      .csn_i        (csn_i),
      .mosi_i       (mosi_i),
      .link_rst_n_i (r.link_rst_n),
      .view_i       (view_mix),
      .deliver_o    (deliver),
      .miso_o       (miso_o),
      .miso_oe_n_o  (miso_oe_n_o)
   );

   // Register view crosses as slow levels; it only changes between frames
   rcr_sync #(
      .WIDTH ($bits(rcr_pkg::rcr_view_type))
   ) u_view_sync (
      .clk_i  (sck_i),
      .nrst_i (r.link_rst_n),
      .d_i    (view),
      .q_o    (view_link)
   );

   // Request toggle crosses back; the held request is stable by then
   rcr_sync #(
      .WIDTH (1)
   ) u_req_sync (
      .clk_i  (clk_sys_i),
      .nrst_i (nrst_i),
      .d_i    (deliver.toggle),
      .q_o    (tog_sync)
   );

   // ==========================================================================
   // Readable image of the registers
   always_comb begin
      view.status   = {r.bank, r.flags, `RCR_STATUS_PIPE_EMPTY, 1'b0};
      view.cfg      = {1'b0, r.cfg[`RCR_BIT_MASK_HI:`RCR_BIT_MASK_LO], r.crc_eff,
                       r.cfg[`RCR_BIT_CRC_LEN:`RCR_BIT_PRIMARY_ROLE_SELECT]};
      view.auto_ack = r.aa;
      view.rx_pipes = r.rxen;
   end

   // Bank bit skips the chain: it only moves between frames, yet the host
   // samples it before the first link edge. Other status bits lag two edges.
   always_comb begin
      view_mix           = view_link;
      view_mix.status[7] = view.status[7];
   end

   // ==========================================================================
   // Next state: apply handed-over writes, keep flags, drive interrupt
   always_comb begin
      nx            = r;
      nx.link_rst_n = 1'b1;
      nx.tog_prev   = tog_sync;
      take          = (tog_sync != r.tog_prev);
      wr_bank0      = take && deliver.req.kind == rcr_pkg::RCR_REQ_WRITE && !deliver.req.bank;
      clr           = 3'h0;
      evt           = {rx_ready_evt_i, tx_done_evt_i, retry_limit_evt_i};
      if (take) begin
         if (deliver.req.kind == rcr_pkg::RCR_REQ_ACTIVATE) begin
            if (deliver.req.data == `RCR_ACT_BANK_DATA) begin
               nx.bank = ~r.bank;
            end
         end else if (!deliver.req.bank) begin
            // Writes assume the host keeps to standby or power-down
            case (deliver.req.addr)
               `RCR_ADDR_CONFIG:   nx.cfg  = deliver.req.data & `RCR_CFG_MASK;
               `RCR_ADDR_AUTO_ACK: nx.aa   = deliver.req.data & `RCR_PIPE_MASK;
               `RCR_ADDR_RX_PIPES: nx.rxen = deliver.req.data & `RCR_PIPE_MASK;
               `RCR_ADDR_STATUS:   clr = deliver.req.data[`RCR_BIT_CLR_HI:`RCR_BIT_CLR_LO];
               default:            clr = 3'h0;
            endcase
         end
      end
      // A new event beats a clear in the same cycle
      nx.flags   = (r.flags & ~clr) | evt;
      nx.crc_eff = nx.cfg[`RCR_BIT_CRC_EN] | (|nx.aa);
      nx.irq_n   = ~|(nx.flags & ~nx.cfg[`RCR_BIT_MASK_HI:`RCR_BIT_MASK_LO]);
   end

   // Single state register, synchronous reset
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         r <= RST_STATE;
      end else begin
         r <= nx;
      end
   end

   // ==========================================================================
   // Outputs, all from the state register
   assign irq_n_o           = r.irq_n;
   assign power_up_o        = r.cfg[`RCR_BIT_POWER_UP_CONTROL];
   assign primary_role_o    = r.cfg[`RCR_BIT_PRIMARY_ROLE_SELECT];
   assign crc_enable_o      = r.crc_eff;
   assign checksum_length_o = r.cfg[`RCR_BIT_CRC_LEN];
   assign auto_ack_o        = r.aa[5:0];
   assign rx_pipe_en_o      = r.rxen[5:0];
   assign bank_o            = r.bank;

   // ==========================================================================
   // Checks on the system clock
   default clocking cb_sys @(posedge clk_sys_i);
   endclocking

   default disable iff (!nrst_i);

   // Unmasked receive event pulls the pin low next cycle
   irq_rx_low_a: assert property (
      rx_ready_evt_i && !nx.cfg[`RCR_BIT_MASK_HI] |=> !irq_n_o
   ) else $error("unmasked receive event did not pull interrupt low");

   // All masks set keep the pin high
   irq_masked_a: assert property (
      nx.cfg[`RCR_BIT_MASK_HI:`RCR_BIT_MASK_LO] == 3'h7 |=> irq_n_o
   ) else $error("interrupt asserted while every event is masked");

   // Any auto-ack pipe forces checksum on
   crc_forced_a: assert property (
      (|auto_ack_o) |-> crc_enable_o
   ) else $error("checksum enable not forced by auto acknowledge");

   // Checksum defaults after reset
   crc_reset_a: assert property (
      $rose(nrst_i) |-> !checksum_length_o && crc_enable_o
   ) else $error("checksum fields wrong after reset");

   // Power and role default off
   power_reset_a: assert property (
      $rose(nrst_i) |-> !power_up_o && !primary_role_o ##1 !power_up_o
   ) else $error("power or role not cleared after reset");

   // Auto-ack pipes on after reset, top bits always clear
   aa_reset_a: assert property (
      $rose(nrst_i) |-> auto_ack_o == 6'h3f && r.aa[7:6] == 2'h0
   ) else $error("auto acknowledge reset value wrong");

   aa_reserved_a: assert property (
      r.aa[7:6] == 2'h0 && r.rxen[7:6] == 2'h0
   ) else $error("reserved pipe bits became set");

   // Only pipes 0 and 1 receive after reset
   rxen_reset_a: assert property (
      $rose(nrst_i) |-> rx_pipe_en_o == 6'h03
   ) else $error("receive pipe enables wrong after reset");

   // Bank toggles exactly on the activate data
   bank_toggle_a: assert property (
      take && deliver.req.kind == rcr_pkg::RCR_REQ_ACTIVATE &&
      deliver.req.data == `RCR_ACT_BANK_DATA |=> bank_o != $past(bank_o)
   ) else $error("bank did not toggle on activate");

   bank_steady_a: assert property (
      !take |=> $stable(bank_o)
   ) else $error("bank changed without a command");

   // Status image reports the bank in its top bit
   status_bank_a: assert property (
      take |-> ##1 view.status[7] == bank_o
   ) else $error("status bank bit disagrees with bank");

   // Receive event sets the flag even against a clear
   rx_flag_set_a: assert property (
      rx_ready_evt_i |=> r.flags[`RCR_BIT_FLAG_RX] ##1 r.flags[`RCR_BIT_FLAG_RX] || $past(take)
   ) else $error("receive flag lost its event");

   // Writing one clears the flag when no event competes
   rx_flag_clear_a: assert property (
      take && deliver.req.kind == rcr_pkg::RCR_REQ_WRITE && !deliver.req.bank &&
      deliver.req.addr == `RCR_ADDR_STATUS && deliver.req.data[`RCR_BIT_CLR_HI] &&
      !rx_ready_evt_i |=> !r.flags[`RCR_BIT_FLAG_RX]
   ) else $error("receive flag not cleared by written one");

   // ==========================================================================
   // Checks on writes handed over from the link

   // Any written one clears its flag unless an event lands with it
   flag_clear_all_a: assert property (
      wr_bank0 && deliver.req.addr == `RCR_ADDR_STATUS |=>
      (r.flags & $past(deliver.req.data[`RCR_BIT_CLR_HI:`RCR_BIT_CLR_LO]) & ~$past(evt)) == 3'h0
   ) else $error("written one left a flag set");

   // Flags never drop without a handed-over request
   flag_hold_a: assert property (
      !take |=> (r.flags & $past(r.flags)) == $past(r.flags)
   ) else $error("flag dropped without a clear");

   // Pin level follows the unmasked flags
   irq_level_a: assert property (
      irq_n_o == ((r.flags & ~r.cfg[`RCR_BIT_MASK_HI:`RCR_BIT_MASK_LO]) == 3'h0)
   ) else $error("interrupt pin disagrees with flags and masks");

   // Checksum enable follows its bit once no pipe forces it
   crc_follow_a: assert property (
      !(|auto_ack_o) |-> crc_enable_o == r.cfg[`RCR_BIT_CRC_EN]
   ) else $error("checksum enable disagrees with its bit");

   // Config write lands in length, power and role
   cfg_write_a: assert property (
      wr_bank0 && deliver.req.addr == `RCR_ADDR_CONFIG |=>
      {checksum_length_o, power_up_o, primary_role_o} ==
      $past(deliver.req.data[`RCR_BIT_CRC_LEN:`RCR_BIT_PRIMARY_ROLE_SELECT])
   ) else $error("config write did not land");

   // Power and role stand while nothing is written
   power_hold_a: assert property (
      !wr_bank0 |=> $stable(power_up_o) && $stable(primary_role_o)
   ) else $error("power or role moved without a write");

   // Pipe write lands with the reserved bits dropped
   aa_write_a: assert property (
      wr_bank0 && deliver.req.addr == `RCR_ADDR_AUTO_ACK |=>
      r.aa == ($past(deliver.req.data) & `RCR_PIPE_MASK)
   ) else $error("auto acknowledge write did not land");

   // Second-bank writes touch nothing here
   bank1_ignored_a: assert property (
      take && deliver.req.kind == rcr_pkg::RCR_REQ_WRITE && deliver.req.bank |=>
      $stable(r.cfg) && $stable(r.aa) && $stable(r.rxen)
   ) else $error("second bank write changed a register");

   // Activate with other data leaves the bank alone
   act_other_a: assert property (
      take && deliver.req.kind == rcr_pkg::RCR_REQ_ACTIVATE &&
      deliver.req.data != `RCR_ACT_BANK_DATA |=> $stable(bank_o)
   ) else $error("bank moved on foreign activate data");

   // Each crossed toggle yields a single take pulse
   take_once_a: assert property (
      take |=> !take
   ) else $error("one request taken twice");
endmodule : rcr_top

// ==== test/rcr_host_model.sv ====
// Host model: serial master on the register bank's four-wire link.
// Assumes the bench calls xfer; the link clock stands low between frames.
`timescale 1ns/1ps
module rcr_host_model (
   // Link pins toward the device
   output logic      sck_o,
   output logic      csn_o,
   output logic      mosi_o,
   input  wire logic miso_i
);
   // ==========================================================================
   // Idle link: clock low, frame closed
   initial begin
      sck_o  = 1'b0;
      csn_o  = 1'b1;
      mosi_o = 1'b1;
   end

   // One frame of command and one data byte, link period 12 ns
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                       output logic [7:0] st, output logic [7:0] rdat);
      logic [15:0] w;
      logic [15:0] q;
      w     = {cmd, dat};
      csn_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = w[i];
         #6;
         q[i]  = miso_i;
         sck_o = 1'b1;
         #6;
         sck_o = 1'b0;
      end
      #6;
      csn_o  = 1'b1;
      mosi_o = ~w[0]; // Stale bit never lingers on the idle line
      st     = q[15:8];
      rdat   = q[7:0];
      #60; // Frame gap above the minimum inactive time
   endtask : xfer
endmodule : rcr_host_model

// ==== test/radio_config_register_bank_bench.sv ====
// Bench for the radio register bank: link reads and writes, events, bank toggle.
// Assumes the host model drives the link and the bench drives events and reset.
`timescale 1ns/1ps
module radio_config_register_bank_bench;
   logic       clk_sys_i, nrst_i, sck, chip_select_n, mosi, miso, miso_oe_n, irq_n;
   logic       rx_evt, tx_evt, rt_evt, pwr, role, crc, clen, bank;
   logic [5:0] aa, rxen;
   logic [7:0] st, rv;
   int         n_fail, n_tests, cyc;

   // ==========================================================================
   // Device and host
   rcr_top i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sck_i(sck), .csn_i(chip_select_n),
      .mosi_i(mosi), .miso_o(miso), .miso_oe_n_o(miso_oe_n), .rx_ready_evt_i(rx_evt),
      .tx_done_evt_i(tx_evt), .retry_limit_evt_i(rt_evt), .irq_n_o(irq_n),
      .power_up_o(pwr), .primary_role_o(role), .crc_enable_o(crc),
      .checksum_length_o(clen), .auto_ack_o(aa), .rx_pipe_en_o(rxen), .bank_o(bank));
   rcr_host_model i_host (.sck_o(sck), .csn_o(chip_select_n), .mosi_o(mosi), .miso_i(miso));

   // System clock, 8 ns
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Hang guard, well above the roughly 1300 cycles the run needs
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         wrap_up();
      end
   end

   // ==========================================================================
   // Tasks
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      i_host.xfer({3'h0, a}, 8'hff, st, rv);
      chk(rv, exp);
   endtask : rchk

   // Settle time covers the crossing into the system clock
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      i_host.xfer({3'h1, a}, v, st, rv);
      repeat (6) @(posedge clk_sys_i);
   endtask : wr

   task automatic cmd(input logic [7:0] c, input logic [7:0] v);
      i_host.xfer(c, v, st, rv);
      repeat (6) @(posedge clk_sys_i);
   endtask : cmd

   task automatic pulse(input int k);
      @(posedge clk_sys_i);
      {rx_evt, tx_evt, rt_evt} <= 3'h4 >> k;
      @(posedge clk_sys_i);
      {rx_evt, tx_evt, rt_evt} <= 3'h0;
      repeat (2) @(posedge clk_sys_i);
   endtask : pulse

   task automatic wrap_up;
      if (n_fail == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up

   // ==========================================================================
   // Main sequence
   initial begin
      nrst_i = 1'b0;
      {rx_evt, tx_evt, rt_evt} = 3'h0;
      n_fail = 0;
      n_tests = 0;
      cyc = 0;
      repeat (10) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      #100;
      chk({pwr, role, crc, clen, bank, irq_n, 2'h0}, 8'h24);
      chk({2'h0, aa}, 8'h3f);
      chk({2'h0, rxen}, 8'h03);
      chk({7'h0, miso_oe_n}, 8'h01);
      rchk(5'h00, 8'h08);
      rchk(5'h01, 8'h3f);
      rchk(5'h02, 8'h03);
      cmd(8'hff, 8'hff);
      chk(st, 8'h0e);
      // Reserved bits drop, checksum enable forced by auto-ack
      wr(5'h01, 8'hff);
      rchk(5'h01, 8'h3f);
      wr(5'h00, 8'hf1);
      rchk(5'h00, 8'h79);
      chk({5'h0, pwr, role, crc}, 8'h03);
      wr(5'h01, 8'h00);
      wr(5'h00, 8'h06);
      rchk(5'h00, 8'h06);
      chk({5'h0, pwr, crc, clen}, 8'h05);
      wr(5'h02, 8'hd4);
      rchk(5'h02, 8'h14);
      chk({2'h0, rxen}, 8'h14);
      // Each event masked, then unmasked, then cleared
      for (int k = 0; k < 3; k++) begin
         wr(5'h00, 8'h70);
         pulse(k);
         chk({7'h0, irq_n}, 8'h01);
         rchk(5'h07, 8'h0e | (8'h40 >> k));
         wr(5'h00, 8'h70 & ~(8'h40 >> k));
         chk({7'h0, irq_n}, 8'h00);
         wr(5'h07, 8'h40 >> k);
         chk({7'h0, irq_n}, 8'h01);
         rchk(5'h07, 8'h0e);
      end
      // Bank toggling: only the 0x53 data byte switches
      wr(5'h00, 8'h00);
      cmd(8'h50, 8'h73);
      chk({7'h0, bank}, 8'h00);
      cmd(8'h50, 8'h53);
      chk({7'h0, bank}, 8'h01);
      cmd(8'hff, 8'hff);
      chk(st, 8'h8e);
      rchk(5'h00, 8'h00);
      wr(5'h00, 8'h03);
      cmd(8'h50, 8'h53);
      chk({7'h0, bank}, 8'h00);
      rchk(5'h00, 8'h00);
      wrap_up();
   end
endmodule : radio_config_register_bank_bench
